// ==== wdg_top.sv ====
/*
 Watchdog timer: 16-bit counter, reload register, prescalers, refresh
 window logic, status flag and internal reset generation.
 Assumes a register port with one-cycle strobes and reads answered
 one cycle later; all inputs synchronous to core_clk.
*/
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "wdg_consts.svh"

module wdg_top #(
   parameter int unsigned ARM_CYCLES = `WDG_ARM_CYCLES,
   parameter int unsigned DIV_BASE   = `WDG_DIV_BASE,
   parameter int unsigned DIV_EXT    = `WDG_DIV_EXT
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             autostart_pin,
   input  wire logic [7:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic [7:0]            reg_rdata,
   output logic                  wd_status,
   output logic                  priority_flag,
   output logic                  device_reset,
   output wdg_pkg::wdg_state_type run_state
);
   import wdg_pkg::*;

   if (ARM_CYCLES < 1 || ARM_CYCLES > 15) begin : g_bad_arm
      $error("wdg_top: ARM_CYCLES must lie in 1..15");
   end

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic          src_q;
   logic          src_d;
   logic          int_rst_q;
   logic          int_rst_d;
   logic          clear;

   logic [7:0]    rel_q;
   logic [7:0]    rel_d;
   logic [7:0]    interrupt_enable_low_q;
   logic [7:0]    interrupt_enable_low_d;
   logic [7:0]    interrupt_enable_high_q;
   logic [7:0]    interrupt_enable_high_d;
   logic [7:0]    rdata_q;
   logic [7:0]    rdata_d;

   logic          arm_q;
   logic          arm_d;
   logic [3:0]    arm_cnt_q;
   logic [3:0]    arm_cnt_d;
   logic          start_q;
   logic          start_d;
   logic [3:0]    start_cnt_q;
   logic [3:0]    start_cnt_d;

   wdg_state_type state_q;
   wdg_state_type state_d;
   logic [15:0]   cnt_q;
   logic [15:0]   cnt_d;

   logic          tick;
   logic          arm_set_w;
   logic          start_set_w;
   logic          refresh;
   logic          running;

   // a lone pin cycle must not stop a running count
   assign clear       = int_rst_q;
   assign running     = (state_q == WDG_RUNNING);
   assign arm_set_w   = reg_wr && (reg_addr == `WDG_ADDR_IEN_LOW)
                        && reg_wdata[`WDG_FLAG_BIT];
   assign start_set_w = reg_wr && (reg_addr == `WDG_ADDR_IEN_HIGH)
                        && reg_wdata[`WDG_FLAG_BIT];
   assign refresh     = start_set_w && arm_q;

   // ----------------------------------------
   // Internal reset generation
   // ----------------------------------------
   // status async from count
   assign wd_status     = running && (cnt_q == `WDG_TERMINAL);
   assign priority_flag = wd_status;

   always_comb begin
      src_d     = rst || wd_status;
      int_rst_d = src_d && src_q;
   end

   always_ff @(posedge core_clk) begin
      src_q     <= src_d;
      int_rst_q <= int_rst_d;
   end

   assign device_reset = int_rst_q;

   // ----------------------------------------
   // Prescaler chain
   // ----------------------------------------
   // 24 or 384 cycles per step
   wdg_prescale #(
      .DIV_BASE (DIV_BASE),
      .DIV_EXT  (DIV_EXT)
   ) u_prescale (
      .core_clk (core_clk),
      .clear    (clear || !running),
      .run      (running),
      .ext_sel  (rel_q[`WDG_PRESCALE_BIT]),
      .tick     (tick)
   );

   // ----------------------------------------
   // Arm and start flags
   // ----------------------------------------
   always_comb begin
      arm_d       = arm_q;
      arm_cnt_d   = arm_cnt_q;
      start_d     = start_q;
      start_cnt_d = start_cnt_q;
      if (arm_q) begin
         arm_cnt_d = arm_cnt_q - `WDG_CNT_ONE;
         if (arm_cnt_q == `WDG_CNT_ONE) begin
            arm_d = 1'b0;
         end
      end
      if (refresh) begin
         arm_d     = 1'b0;
         arm_cnt_d = `WDG_CNT_ZERO;
      end
      if (arm_set_w) begin
         arm_d     = 1'b1;
         arm_cnt_d = 4'(ARM_CYCLES);
      end
      if (start_q) begin
         start_cnt_d = start_cnt_q - `WDG_CNT_ONE;
         if (start_cnt_q == `WDG_CNT_ONE) begin
            start_d = 1'b0;
         end
      end
      if (start_set_w) begin
         start_d     = 1'b1;
         start_cnt_d = 4'(ARM_CYCLES);
      end
   end

   always_ff @(posedge core_clk) begin
      if (clear) begin
         arm_q       <= 1'b0;
         arm_cnt_q   <= `WDG_CNT_ZERO;
         start_q     <= 1'b0;
         start_cnt_q <= `WDG_CNT_ZERO;
      end else begin
         arm_q       <= arm_d;
         arm_cnt_q   <= arm_cnt_d;
         start_q     <= start_d;
         start_cnt_q <= start_cnt_d;
      end
   end

   // ----------------------------------------
   // Run state and counter
   // ----------------------------------------
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      if (clear) begin
         state_d = autostart_pin ? WDG_RUNNING : WDG_STOPPED;
         cnt_d   = `WDG_ZERO16;
      end else begin
         unique case (state_q)
            WDG_STOPPED: begin
               if (start_set_w) begin
                  state_d = WDG_RUNNING;
               end
            end
            WDG_RUNNING: begin
               state_d = WDG_RUNNING;
               if (tick) begin
                  cnt_d = cnt_q + `WDG_ONE16;
               end
            end
         endcase
         if (refresh) begin
            // low byte and bit 15 cleared
            cnt_d = {1'b0, rel_q[6:0], `WDG_ZERO8};
         end
      end
   end

   always_ff @(posedge core_clk) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
   end

   assign run_state = state_q;

   // ----------------------------------------
   // Register port
   // ----------------------------------------
   always_comb begin
      rel_d   = rel_q;
      interrupt_enable_low_d  = interrupt_enable_low_q;
      interrupt_enable_high_d  = interrupt_enable_high_q;
      rdata_d = `WDG_ZERO8;
      if (reg_wr) begin
         unique case (reg_addr)
            `WDG_ADDR_RELOAD:   rel_d  = reg_wdata;
            `WDG_ADDR_IEN_LOW:  interrupt_enable_low_d = reg_wdata;
            `WDG_ADDR_IEN_HIGH: interrupt_enable_high_d = reg_wdata;
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            `WDG_ADDR_RELOAD: rdata_d = rel_q;
            `WDG_ADDR_IEN_LOW: begin
               rdata_d                = interrupt_enable_low_q;
               rdata_d[`WDG_FLAG_BIT] = arm_q;
            end
            `WDG_ADDR_IEN_HIGH: begin
               rdata_d                = interrupt_enable_high_q;
               // status read in place of start
               rdata_d[`WDG_FLAG_BIT] = running;
               rdata_d[`WDG_RSVD_BIT] = 1'b0;
            end
            default: rdata_d = `WDG_ZERO8;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (clear) begin
         rel_q   <= `WDG_ZERO8;
         interrupt_enable_low_q  <= `WDG_ZERO8;
         interrupt_enable_high_q  <= `WDG_ZERO8;
         rdata_q <= `WDG_ZERO8;
      end else begin
         rel_q   <= rel_d;
         interrupt_enable_low_q  <= interrupt_enable_low_d;
         interrupt_enable_high_q  <= interrupt_enable_high_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence arm_quiet_s;
      !arm_set_w && !start_set_w && !int_rst_q;
   endsequence

   sequence start_quiet_s;
      !start_set_w && !int_rst_q;
   endsequence

   sequence arm_written_s;
      arm_set_w && !int_rst_q;
   endsequence

   // Terminal count must reach internal reset in two edges
   chk_status_resets: assert property (
      wd_status && !src_q && !int_rst_q |-> ##2 int_rst_q)
      else $error("terminal count did not raise internal reset");

   chk_rst_two_cycles: assert property (
      src_d && src_q |=> int_rst_q)
      else $error("internal reset missing after two source cycles");

   chk_rst_single: assert property (
      !src_q |=> !int_rst_q)
      else $error("internal reset after a single source cycle");

   chk_arm_holds: assert property (
      arm_written_s ##1 arm_quiet_s [*8] |-> arm_q)
      else $error("arm flag dropped before its window ended");

   chk_arm_expires: assert property (
      arm_written_s ##1 arm_quiet_s [*8] ##1 arm_quiet_s [*4] |=> !arm_q)
      else $error("arm flag outlived its window");

   chk_start_expires: assert property (
      start_set_w && !int_rst_q ##1 start_quiet_s [*8] ##1 start_quiet_s [*4] |=> !start_q)
      else $error("start flag outlived its window");

   chk_refresh_load: assert property (
      refresh && !int_rst_q |=>
         cnt_q == {1'b0, $past(rel_q[6:0]), `WDG_ZERO8} && !arm_q)
      else $error("refresh did not reload counter");

   chk_late_start: assert property (
      running && start_set_w && !arm_q && !tick && !int_rst_q |=>
         cnt_q == $past(cnt_q))
      else $error("start outside window changed the counter");

   chk_no_stop: assert property (
      running && !int_rst_q |=> running)
      else $error("running watchdog stopped without reset");

   chk_stay_stopped: assert property (
      !running && !start_set_w && !int_rst_q |=> !running)
      else $error("stopped watchdog started by itself");

   chk_autostart: assert property (
      int_rst_q |=> running == $past(autostart_pin) && cnt_q == `WDG_ZERO16)
      else $error("autostart strap not honoured");

   chk_count_step: assert property (
      running && tick && !refresh && !int_rst_q |=> cnt_q == $past(cnt_q) + `WDG_ONE16)
      else $error("counter did not step on tick");

   chk_read_status: assert property (
      reg_rd && reg_addr == `WDG_ADDR_IEN_HIGH && !int_rst_q |=>
         reg_rdata[`WDG_FLAG_BIT] == $past(running))
      else $error("status bit read back wrongly");

   chk_reload_back: assert property (
      reg_wr && reg_addr == `WDG_ADDR_RELOAD && !int_rst_q ##1
      reg_rd && reg_addr == `WDG_ADDR_RELOAD && !int_rst_q |=>
         reg_rdata == $past(reg_wdata, 2))
      else $error("reload register did not read back");

endmodule
`default_nettype wire

// ==== wdg_consts.svh ====
/*
 Constants for the watchdog block: register offsets, bit positions,
 reset values and timing counts. Assumes inclusion by bare name.
*/
`ifndef WDG_CONSTS_SVH
`define WDG_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define WDG_ADDR_RELOAD     8'h86
`define WDG_ADDR_IEN_LOW    8'hA8
`define WDG_ADDR_IEN_HIGH   8'hB8

// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define WDG_FLAG_BIT        6
`define WDG_PRESCALE_BIT    7
`define WDG_RSVD_BIT        7
`define WDG_TERMINAL        16'h7CFF
`define WDG_ZERO8           8'h00
`define WDG_ZERO16          16'h0000
`define WDG_ONE16           16'h0001
`define WDG_CNT_ONE         4'h1
`define WDG_CNT_ZERO        4'h0

// ----------------------------------------
// Timing counts in core clock cycles; WDG_DIV_EXT is a multiplier of WDG_DIV_BASE
// ----------------------------------------
`define WDG_ARM_CYCLES      12
`define WDG_DIV_BASE        24
`define WDG_DIV_EXT         16

`endif

// ==== wdg_pkg.sv ====
/*
 Types shared by the watchdog design files.
 Assumes nothing of its surroundings.
*/
package wdg_pkg;

   typedef enum logic [0:0] {
      WDG_STOPPED = 1'b0,
      WDG_RUNNING = 1'b1
   } wdg_state_type;

endpackage

// ==== wdg_prescale.sv ====
/*
 Prescaler chain of the watchdog: emits one tick per counter step.
 Assumes the caller clears it with the block's internal reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wdg_consts.svh"

module wdg_prescale #(
   parameter int unsigned DIV_BASE = `WDG_DIV_BASE,
   parameter int unsigned DIV_EXT  = `WDG_DIV_EXT
) (
   input  wire logic core_clk,
   input  wire logic clear,
   input  wire logic run,
   input  wire logic ext_sel,
   output logic      tick
);
   import wdg_pkg::*;

   localparam int unsigned LIMIT = DIV_BASE * DIV_EXT;
   localparam int unsigned CW    = $clog2(LIMIT + 1);

   if (DIV_BASE < 2 || DIV_EXT < 1) begin : g_bad
      $error("wdg_prescale: divider values out of range");
   end

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic          tick_q;
   logic          tick_d;
   logic [CW-1:0] last;

   // ----------------------------------------
   // Divide chain
   // ----------------------------------------
   always_comb begin
      last   = ext_sel ? CW'(LIMIT - 1) : CW'(DIV_BASE - 1);
      cnt_d  = cnt_q;
      tick_d = 1'b0;
      if (run) begin
         if (cnt_q >= last) begin
            cnt_d  = '0;
            tick_d = 1'b1;
         end else begin
            cnt_d = cnt_q + CW'(1);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (clear) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;

endmodule
`default_nettype wire

// ==== tb_wdg_top.sv ====
/*
 Self-checking bench for the watchdog block: register port, start,
 refresh window, terminal count and internal reset.
 Assumes wdg_top, wdg_pkg and wdg_consts.svh compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wdg_consts.svh"

module tb_wdg_top;
   import wdg_pkg::*;

   // ----------------------------------------
   // Short counts keep the terminal run brief
   // ----------------------------------------
   localparam int DB = 2;
   localparam int DE = 2;
   localparam int AC = 12;

   logic          core_clk;
   logic          rst;
   logic          autostart_pin;
   logic [7:0]    reg_addr;
   logic [7:0]    reg_wdata;
   logic          reg_wr;
   logic          reg_rd;
   logic [7:0]    reg_rdata;
   logic          wd_status;
   logic          priority_flag;
   logic          device_reset;
   wdg_state_type run_state;
   int            n_mismatch;
   int            checks;
   int            seed;

   wdg_top #(.ARM_CYCLES(AC), .DIV_BASE(DB), .DIV_EXT(DE)) i_wdg_top (
      .core_clk     (core_clk),
      .rst          (rst),
      .autostart_pin(autostart_pin),
      .reg_addr     (reg_addr),
      .reg_wdata    (reg_wdata),
      .reg_wr       (reg_wr),
      .reg_rd       (reg_rd),
      .reg_rdata    (reg_rdata),
      .wd_status    (wd_status),
      .priority_flag(priority_flag),
      .device_reset (device_reset),
      .run_state    (run_state)
   );

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic refresh(input logic [7:0] rel);
      wr(`WDG_ADDR_RELOAD, rel);
      wr(`WDG_ADDR_IEN_LOW, 8'h40);
      wr(`WDG_ADDR_IEN_HIGH, 8'h40);
   endtask

   // Cycles from refresh to terminal count, prescaler phase unknown
   function automatic int span(input logic [7:0] rel);
      int s;
      s = int'(16'h7CFF) - int'({1'b0, rel[6:0], 8'h00});
      return s * (rel[7] ? DB * DE : DB);
   endfunction

   task automatic wait_status(input int lo, input int hi);
      int n;
      n = 0;
      while (wd_status !== 1'b1 && n < hi + 5) begin
         @(posedge core_clk);
         #1 n++;
      end
      chk(8'(n >= lo && n <= hi), 8'h01);
   endtask

   task automatic close_out;
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      #100us;
      n_mismatch++;
      close_out();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [7:0] d;
      logic [7:0] r;
      int         n;
      seed = 45;
      n_mismatch = 0;
      checks = 0;
      rst = 1'b1;
      autostart_pin = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      rd(`WDG_ADDR_RELOAD, d);
      chk(d, 8'h00);
      rd(`WDG_ADDR_IEN_HIGH, d);
      chk(d, 8'h00);
      rd(8'h90, d);
      chk(d, 8'h00);
      chk(8'(run_state), 8'(WDG_STOPPED));
      $display("test reset done");
      // one high cycle is not enough
      @(posedge core_clk);
      rst <= 1'b1;
      @(posedge core_clk);
      rst <= 1'b0;
      repeat (3) begin
         @(posedge core_clk);
         #1 chk(8'(device_reset), 8'h00);
      end
      $display("test short pulse done");
      r = 8'($random(seed));
      wr(`WDG_ADDR_RELOAD, r);
      rd(`WDG_ADDR_RELOAD, d);
      chk(d, r);
      // write then read with no gap
      r = 8'($random(seed));
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= `WDG_ADDR_RELOAD;
      reg_wdata <= r;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b1;
      @(posedge core_clk);
      reg_rd    <= 1'b0;
      #1 chk(reg_rdata, r);
      r = 8'($random(seed)) | 8'h40;
      wr(`WDG_ADDR_IEN_LOW, r);
      rd(`WDG_ADDR_IEN_LOW, d);
      chk(d, r);
      repeat (AC + 2) @(posedge core_clk);
      rd(`WDG_ADDR_IEN_LOW, d);
      chk(d, r & 8'hBF);
      chk(8'(run_state), 8'(WDG_STOPPED));
      $display("test arm done");
      r = 8'($random(seed)) | 8'h40;
      wr(`WDG_ADDR_IEN_HIGH, r);
      rd(`WDG_ADDR_IEN_HIGH, d);
      chk(d, {2'b01, r[5:0]});
      chk(8'(run_state), 8'(WDG_RUNNING));
      // writing zero does not stop it
      wr(`WDG_ADDR_IEN_HIGH, 8'h00);
      repeat (AC + 4) @(posedge core_clk);
      rd(`WDG_ADDR_IEN_HIGH, d);
      chk(d[6], 1'b1);
      chk(8'(run_state), 8'(WDG_RUNNING));
      // a one-cycle pin pulse leaves it running
      @(posedge core_clk);
      rst <= 1'b1;
      @(posedge core_clk);
      rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1 chk(8'(run_state), 8'(WDG_RUNNING));
      $display("test start done");
      // reload and prescale choice reach terminal count
      for (int i = 0; i < 2; i++) begin
         r = {i == 1, 7'h7B + 7'(($random(seed) & 1))};
         autostart_pin <= i[0];
         refresh(r);
         wait_status(span(r) - (r[7] ? DB * DE : DB), span(r) + DB * DE + 3);
         chk(8'(priority_flag), 8'h01);
         repeat (2) @(posedge core_clk);
         #1 chk(8'(device_reset), 8'h01);
         n = 0;
         while (device_reset !== 1'b0 && n < 10) begin
            @(posedge core_clk);
            #1 n++;
         end
         chk(8'(wd_status), 8'h00);
         repeat (2) @(posedge core_clk);
         chk(8'(run_state), 8'(i[0]));
         rd(`WDG_ADDR_RELOAD, d);
         chk(d, 8'h00);
         $display("test terminal %0d done", i);
      end
      wr(`WDG_ADDR_RELOAD, 8'h7C);
      wr(`WDG_ADDR_IEN_LOW, 8'h40);
      repeat (AC + 2) @(posedge core_clk);
      wr(`WDG_ADDR_IEN_HIGH, 8'h40);
      n = 0;
      repeat (span(8'h7C) + 40) begin
         @(posedge core_clk);
         #1 n += wd_status;
      end
      chk(8'(n), 8'h00);
      refresh(8'h7C);
      wait_status(span(8'h7C) - DB, span(8'h7C) + DB + 3);
      $display("test window done");
      close_out();
   end
endmodule

`default_nettype wire
